//--- rtl/pms_mode_seq.sv
// Operating-mode sequencer: STOP, START-UP, RUN and HOLD control, image
// transfer ordering, supervision, breakpoint limits and overall reset.
// Assumes core handshakes are on core_clk; switch pins are asynchronous.
//
// Behaviour
// - Always exactly one of four modes
// - STOP: no execution, outputs off, stop lit
// - Entering STOP keeps images, timers, counters
// - STOP to RUN runs unsupervised startup routine
// - START-UP: inhibit asserted, stop indicator off
// - Run indicator blinks at least 3s
// - Startup routine done moves to RUN
// - RUN cycles main routine, timers active
// - RUN: inhibit released, run lit, stop off
// - At most three breakpoints accepted
// - Breakpoint hit enters HOLD, step or resume
// - HOLD: run blinks, stop steady on
// - HOLD: halt, freeze timers, inhibit outputs
// - Step refused with more than two breakpoints
// - Watchdog and cycle limit force STOP
// - RUN to STOP asserts output inhibit
// - RUN to STOP drives analog safe values
// - Clear inputs, startup, release, then cycle
// - Cycle order: read, main, write
// - Overall reset erases user memory only
// - Stop indicator blinks during overall reset
`include "pms_consts.svh"
module pms_mode_seq #(
	parameter int WDOG_CYC  = `PMS_WDOG_MS * (`PMS_CLK_HZ / 1000),
	parameter int MS_CYC    = `PMS_CLK_HZ / 1000,
	parameter int BLINK_CYC = `PMS_BLINK_MS * (`PMS_CLK_HZ / 1000),
	parameter int HALF_CYC  = `PMS_HALF_MS * (`PMS_CLK_HZ / 1000)
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [3:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             run_sw,
	input  wire logic             mres_sw,
	input  wire logic             img_done,
	input  wire logic             startup_done,
	input  wire logic             main_done,
	input  wire logic             bp_hit,
	input  wire logic             erase_done,
	output pms_pkg::pms_cmd_s     cmd,
	output pms_pkg::pms_lvl_s     lvl
);
	// ==========================================
	// State
	pms_pkg::pms_mode_e  mode_r;
	pms_pkg::pms_phase_e phase_r;
	pms_pkg::pms_cmd_s   cmd_r;
	pms_pkg::pms_lvl_s   lvl_r;
	logic [31:0] rdata_r;
	logic        wait_r;
	logic [1:0]  bp_cnt_r;
	logic        bp_act_r;
	logic        subst_r;
	logic [15:0] cyclim_r;
	logic [1:0]  run_sync_r;
	logic [1:0]  mres_sync_r;
	logic        run_prev_r;
	logic        mres_prev_r;
	logic        erasing_r;
	logic        wdog_flt_r;
	logic        cyc_flt_r;
	logic        step_ref_r;
	logic [31:0] cyc_cnt_r;
	logic [31:0] ms_cnt_r;
	logic [15:0] ms_r;
	logic [31:0] blink_r;
	logic [31:0] half_r;
	logic        tog_r;
	logic        wr_take;
	logic        go_run;
	logic        go_stop;
	logic        do_mres;
	logic        do_step;
	logic        do_resume;
	logic        wdog_hit;
	logic        cyc_hit;
	logic        fault;
	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;
	assign cmd             = cmd_r;
	assign lvl             = lvl_r;
	// ==========================================
	// Bus slave: one wait cycle, then answer
	assign wr_take = avs_write && !wait_r;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wait_r <= 1'b1;
		end else if ((avs_read || avs_write) && wait_r) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end
	// Read data, unmapped offsets read zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_r <= 32'h0;
		end else if (avs_read && wait_r) begin
			unique case (avs_address)
				`PMS_OFF_BRKP:   rdata_r <= {28'h0, subst_r, bp_act_r, bp_cnt_r};
				`PMS_OFF_CYCLIM: rdata_r <= {16'h0, cyclim_r};
				`PMS_OFF_STAT:   rdata_r <= {22'h0, step_ref_r, cyc_flt_r, wdog_flt_r, erasing_r, 1'b0, phase_r, mode_r};
				default:         rdata_r <= 32'h0;
			endcase
		end
	end
	// Configuration writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bp_cnt_r <= 2'h0;
			bp_act_r <= 1'b0;
			subst_r  <= 1'b0;
			cyclim_r <= `PMS_CYCLIM_RST;
		end else if (wr_take && avs_address == `PMS_OFF_BRKP) begin
			bp_cnt_r <= avs_writedata[1:0]; // Two-bit field caps it at three
			bp_act_r <= avs_writedata[`PMS_BP_ACT];
			subst_r  <= avs_writedata[`PMS_BP_SUBST];
		end else if (wr_take && avs_address == `PMS_OFF_CYCLIM) begin
			// Limit never below one millisecond
			cyclim_r <= (avs_writedata[15:0] < `PMS_CYCLIM_MIN) ? `PMS_CYCLIM_MIN : avs_writedata[15:0];
		end
	end

	// ==========================================
	// Switch pins: two-flop synchronisers and edges
	always_ff @(posedge core_clk) begin
		if (rst) begin
			run_sync_r  <= 2'h0;
			mres_sync_r <= 2'h0;
			run_prev_r  <= 1'b0;
			mres_prev_r <= 1'b0;
		end else begin
			run_sync_r  <= {run_sync_r[0], run_sw};
			mres_sync_r <= {mres_sync_r[0], mres_sw};
			run_prev_r  <= run_sync_r[1];
			mres_prev_r <= mres_sync_r[1];
		end
	end
	// Requests from software and switch
	wire ctrl_wr = wr_take && avs_address == `PMS_OFF_CTRL;
	assign go_run    = (ctrl_wr && avs_writedata[`PMS_CTRL_RUN]) || (run_sync_r[1] && !run_prev_r);
	assign go_stop   = (ctrl_wr && avs_writedata[`PMS_CTRL_STOP]) || (!run_sync_r[1] && run_prev_r);
	assign do_mres   = (ctrl_wr && avs_writedata[`PMS_CTRL_MRES]) || (mres_sync_r[1] && !mres_prev_r);
	assign do_step   = ctrl_wr && avs_writedata[`PMS_CTRL_STEP];
	assign do_resume = ctrl_wr && avs_writedata[`PMS_CTRL_RESUME];
	assign wdog_hit  = mode_r == pms_pkg::PMS_RUN && cyc_cnt_r == 32'(WDOG_CYC - 1);
	assign cyc_hit   = mode_r == pms_pkg::PMS_RUN && ms_r >= cyclim_r;
	assign fault     = wdog_hit || cyc_hit;

	// ==========================================
	// Cycle supervision, counted only in RUN
	always_ff @(posedge core_clk) begin
		if (rst || mode_r != pms_pkg::PMS_RUN || (phase_r == pms_pkg::PH_WRITE && img_done)) begin
			cyc_cnt_r <= 32'h0;
			ms_cnt_r  <= 32'h0;
			ms_r      <= 16'h0;
		end else begin
			cyc_cnt_r <= cyc_cnt_r + 32'h1;
			if (ms_cnt_r == 32'(MS_CYC - 1)) begin
				ms_cnt_r <= 32'h0;
				ms_r     <= ms_r + 16'h1;
			end else begin
				ms_cnt_r <= ms_cnt_r + 32'h1;
			end
		end
	end
	// Sticky fault and refusal flags, set wins over clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wdog_flt_r <= 1'b0;
			cyc_flt_r  <= 1'b0;
			step_ref_r <= 1'b0;
		end else begin
			wdog_flt_r <= wdog_hit || (wdog_flt_r && !go_run);
			cyc_flt_r  <= cyc_hit || (cyc_flt_r && !go_run);
			step_ref_r <= (do_step && bp_cnt_r > `PMS_BP_STEP_MAX) || (step_ref_r && !do_resume);
		end
	end

	// ==========================================
	// Mode and phase sequencing with pulsed commands
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_r  <= pms_pkg::PMS_STOP;
			phase_r <= pms_pkg::PH_IDLE;
			cmd_r   <= '0;
		end else begin
			cmd_r <= '0;
			unique case (mode_r)
				pms_pkg::PMS_STOP: begin
					// Images kept as they stand on entry
					if (go_run && !erasing_r && !do_mres) begin
						mode_r       <= pms_pkg::PMS_STARTUP;
						phase_r      <= pms_pkg::PH_CLR_IN;
						cmd_r.clr_in <= 1'b1;
					end
				end
				pms_pkg::PMS_STARTUP: begin
					if (go_stop) begin
						mode_r  <= pms_pkg::PMS_STOP;
						phase_r <= pms_pkg::PH_IDLE;
					end else if (phase_r == pms_pkg::PH_CLR_IN && img_done) begin
						phase_r          <= pms_pkg::PH_INIT;
						cmd_r.startup_go <= 1'b1;
					end else if (phase_r == pms_pkg::PH_INIT && startup_done) begin
						mode_r        <= pms_pkg::PMS_RUN;
						phase_r       <= pms_pkg::PH_CLR_OUT;
						cmd_r.clr_out <= 1'b1;
					end
				end
				pms_pkg::PMS_RUN: begin
					if (go_stop || fault) begin
						mode_r  <= pms_pkg::PMS_STOP;
						phase_r <= pms_pkg::PH_IDLE;
					end else if (phase_r == pms_pkg::PH_MAIN && bp_hit && bp_act_r && bp_cnt_r != 2'h0) begin
						mode_r <= pms_pkg::PMS_HOLD;
					end else if (img_done && (phase_r == pms_pkg::PH_CLR_OUT || phase_r == pms_pkg::PH_WRITE)) begin
						phase_r       <= pms_pkg::PH_READ;
						cmd_r.read_in <= 1'b1;
					end else if (phase_r == pms_pkg::PH_READ && img_done) begin
						phase_r       <= pms_pkg::PH_MAIN;
						cmd_r.main_go <= 1'b1;
					end else if (phase_r == pms_pkg::PH_MAIN && main_done) begin
						phase_r         <= pms_pkg::PH_WRITE;
						cmd_r.write_out <= 1'b1;
					end
				end
				pms_pkg::PMS_HOLD: begin
					if (go_stop) begin
						mode_r  <= pms_pkg::PMS_STOP;
						phase_r <= pms_pkg::PH_IDLE;
					end else if (do_resume) begin
						mode_r <= pms_pkg::PMS_RUN;
					end else if (do_step && bp_cnt_r <= `PMS_BP_STEP_MAX) begin
						cmd_r.step_go <= 1'b1;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Overall reset: erase request held until done
	always_ff @(posedge core_clk) begin
		if (rst) begin
			erasing_r <= 1'b0;
		end else if (erasing_r && erase_done) begin
			erasing_r <= 1'b0;
		end else if (do_mres && mode_r == pms_pkg::PMS_STOP) begin
			erasing_r <= 1'b1;
		end
	end
	// Blink timers: minimum start-up blink and toggle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			blink_r <= 32'h0;
			half_r  <= 32'h0;
			tog_r   <= 1'b0;
		end else begin
			if (mode_r == pms_pkg::PMS_STARTUP && phase_r == pms_pkg::PH_CLR_IN) begin
				blink_r <= 32'(BLINK_CYC);
			end else if (blink_r != 32'h0) begin
				blink_r <= blink_r - 32'h1;
			end
			if (half_r == 32'(HALF_CYC - 1)) begin
				half_r <= 32'h0;
				tog_r  <= !tog_r;
			end else begin
				half_r <= half_r + 32'h1;
			end
		end
	end

	// ==========================================
	// Level outputs from the current mode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lvl_r <= '{output_inhibit: 1'b1, stop_indicator: 1'b1, default: 1'b0};
		end else begin
			lvl_r.output_inhibit <= mode_r != pms_pkg::PMS_RUN;
			lvl_r.exec_enable    <= mode_r == pms_pkg::PMS_RUN || mode_r == pms_pkg::PMS_STARTUP;
			lvl_r.timers_run     <= mode_r == pms_pkg::PMS_RUN;
			lvl_r.analog_safe    <= mode_r != pms_pkg::PMS_RUN;
			lvl_r.analog_subst   <= mode_r != pms_pkg::PMS_RUN && subst_r;
			lvl_r.erase_req      <= erasing_r;
			if (mode_r == pms_pkg::PMS_STARTUP || mode_r == pms_pkg::PMS_HOLD || blink_r != 32'h0) begin
				lvl_r.run_indicator <= tog_r;
			end else begin
				lvl_r.run_indicator <= mode_r == pms_pkg::PMS_RUN;
			end
			if (erasing_r) begin
				lvl_r.stop_indicator <= tog_r;
			end else begin
				lvl_r.stop_indicator <= mode_r == pms_pkg::PMS_STOP || mode_r == pms_pkg::PMS_HOLD;
			end
		end
	end

	// ==========================================
	// Checks
	property p_inhibit_stop;
		@(posedge core_clk) disable iff (rst)
		(mode_r == pms_pkg::PMS_RUN) ##1 (mode_r == pms_pkg::PMS_STOP) |=> lvl_r.output_inhibit && lvl_r.analog_safe;
	endproperty
	a_inhibit_stop: assert property (p_inhibit_stop) else $error("inhibit not set after run to stop");
	property p_run_leds;
		@(posedge core_clk) disable iff (rst)
		(mode_r == pms_pkg::PMS_RUN && blink_r == 32'h0)[*2] |-> lvl_r.run_indicator && !lvl_r.stop_indicator
		&& !lvl_r.output_inhibit;
	endproperty
	a_run_leds: assert property (p_run_leds) else $error("run indicators wrong");
	property p_stop_out;
		@(posedge core_clk) disable iff (rst)
		(mode_r == pms_pkg::PMS_STOP && !erasing_r)[*2] |-> lvl_r.stop_indicator && !lvl_r.exec_enable;
	endproperty
	a_stop_out: assert property (p_stop_out) else $error("stop outputs wrong");
	property p_startup;
		@(posedge core_clk) disable iff (rst)
		$past(mode_r) == pms_pkg::PMS_STARTUP |-> lvl_r.output_inhibit && !lvl_r.stop_indicator;
	endproperty
	a_startup: assert property (p_startup) else $error("startup outputs wrong");
	property p_blink_min;
		@(posedge core_clk) disable iff (rst)
		$rose(mode_r == pms_pkg::PMS_STARTUP) |=> blink_r == 32'(BLINK_CYC);
	endproperty
	a_blink_min: assert property (p_blink_min) else $error("blink hold not loaded");
	property p_to_run;
		@(posedge core_clk) disable iff (rst)
		mode_r == pms_pkg::PMS_STARTUP && phase_r == pms_pkg::PH_INIT && startup_done && !go_stop
		|=> mode_r == pms_pkg::PMS_RUN && cmd_r.clr_out;
	endproperty
	a_to_run: assert property (p_to_run) else $error("startup did not enter run");
	property p_order;
		@(posedge core_clk) disable iff (rst)
		cmd_r.main_go |-> $past(phase_r) == pms_pkg::PH_READ;
	endproperty
	a_order: assert property (p_order) else $error("main started out of order");
	property p_step_ref;
		@(posedge core_clk) disable iff (rst)
		bp_cnt_r == `PMS_BP_MAX |-> ##1 !cmd_r.step_go;
	endproperty
	a_step_ref: assert property (p_step_ref) else $error("step with three breakpoints");
	property p_fault;
		@(posedge core_clk) disable iff (rst)
		fault |=> mode_r == pms_pkg::PMS_STOP && (wdog_flt_r || cyc_flt_r);
	endproperty
	a_fault: assert property (p_fault) else $error("fault did not stop");
	property p_hold;
		@(posedge core_clk) disable iff (rst)
		(mode_r == pms_pkg::PMS_HOLD)[*2] |-> lvl_r.stop_indicator && !lvl_r.timers_run && lvl_r.output_inhibit;
	endproperty
	a_hold: assert property (p_hold) else $error("hold outputs wrong");
	c_run: cover property (@(posedge core_clk) disable iff (rst) cmd_r.write_out ##[1:50] cmd_r.read_in);
	c_hold: cover property (@(posedge core_clk) disable iff (rst) mode_r == pms_pkg::PMS_HOLD ##[1:50] cmd_r.step_go);
	c_mres: cover property (@(posedge core_clk) disable iff (rst) $fell(erasing_r));
endmodule : pms_mode_seq

//--- rtl/pms_consts.svh
// Offsets, fields, reset values and timing figures of the mode sequencer.
// Assumes inclusion by bare name from the design module; the package does not include it.
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH
// ==========================================
// Register byte offsets
`define PMS_OFF_CTRL   4'h0
`define PMS_OFF_BRKP   4'h4
`define PMS_OFF_CYCLIM 4'h8
`define PMS_OFF_STAT   4'hc
// ==========================================
// Command bits of the control register
`define PMS_CTRL_RUN    0
`define PMS_CTRL_STOP   1
`define PMS_CTRL_MRES   2
`define PMS_CTRL_STEP   3
`define PMS_CTRL_RESUME 4
// ==========================================
// Breakpoint register fields
`define PMS_BP_MAX      2'h3
`define PMS_BP_STEP_MAX 2'h2
`define PMS_BP_ACT      2
`define PMS_BP_SUBST    3
// ==========================================
// Reset values and timing figures
`define PMS_CYCLIM_RST 16'h0064
`define PMS_CLK_HZ     40000000
`define PMS_WDOG_MS    100
`define PMS_CYCLIM_MIN 16'h0001
`define PMS_BLINK_MS   3000
`define PMS_HALF_MS    250
`endif

//--- rtl/pms_pkg.sv
// Types shared by the mode sequencer and its surroundings.
// Assumes the constants header is on the include path.
package pms_pkg;
	// ==========================================
	// Operating modes and sequencing phases
	typedef enum logic [1:0] {PMS_STOP, PMS_STARTUP, PMS_RUN, PMS_HOLD} pms_mode_e;
	typedef enum logic [2:0] {PH_IDLE, PH_CLR_IN, PH_INIT, PH_CLR_OUT, PH_READ, PH_MAIN, PH_WRITE} pms_phase_e;
	// Pulsed requests to the execution core and image transfer logic
	typedef struct packed {
		logic clr_in;
		logic startup_go;
		logic clr_out;
		logic read_in;
		logic main_go;
		logic write_out;
		logic step_go;
	} pms_cmd_s;
	// Level outputs towards I/O and indicators
	typedef struct packed {
		logic output_inhibit;
		logic run_indicator;
		logic stop_indicator;
		logic exec_enable;
		logic timers_run;
		logic analog_safe;
		logic analog_subst;
		logic erase_req;
	} pms_lvl_s;
endpackage : pms_pkg

//--- bench/pms_core_model.sv
// Behavioural execution core and image transfer partner of the mode sequencer.
// Assumes one-cycle cmd pulses; answers after delays set by the bench.
module pms_core_model (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire pms_pkg::pms_cmd_s cmd,
	input  wire pms_pkg::pms_lvl_s lvl,
	input  wire logic [7:0]        dly,
	input  wire logic [7:0]        su_dly,
	input  wire logic              hang,
	output logic                   img_done,
	output logic                   startup_done,
	output logic                   main_done,
	output logic                   erase_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] img_r;
	logic [7:0] su_r;
	logic [7:0] main_r;
	logic [7:0] er_r;
	// ==========================================
	// Image steps, decentral inputs read on request
	always_ff @(posedge core_clk) begin
		if (rst)
			img_r <= 8'h00;
		else if (cmd.clr_in | cmd.clr_out | cmd.read_in | cmd.write_out)
			img_r <= dly;
		else if (img_r != 8'h00)
			img_r <= img_r - 8'h01;
	end
	assign img_done = (img_r == 8'h01);
	// Startup routine takes su_dly cycles
	always_ff @(posedge core_clk) begin
		if (rst)
			su_r <= 8'h00;
		else if (cmd.startup_go)
			su_r <= su_dly;
		else if (su_r != 8'h00)
			su_r <= su_r - 8'h01;
	end
	assign startup_done = (su_r == 8'h01);
	// Main routine; halts while execution is disabled or hung
	always_ff @(posedge core_clk) begin
		if (rst)
			main_r <= 8'h00;
		else if (cmd.main_go)
			main_r <= dly;
		else if (main_r > 8'h01 || main_done)
			main_r <= main_r - 8'h01;
	end
	assign main_done = (main_r == 8'h01) && lvl.exec_enable && !hang;
	// Memory erase lasts su_dly cycles
	always_ff @(posedge core_clk) begin
		if (rst || !lvl.erase_req)
			er_r <= 8'h00;
		else
			er_r <= er_r + 8'h01;
	end
	assign erase_done = lvl.erase_req && (er_r == su_dly);
endmodule : pms_core_model

//--- bench/testbench.sv
// Self-checking bench for the mode sequencer with a behavioural core.
// Assumes a 40 MHz core_clk and shortened supervision parameters.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic              core_clk;
	logic              rst;
	logic [3:0]        avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic              run_sw;
	logic              mres_sw;
	logic              bp_hit;
	logic              img_done;
	logic              startup_done;
	logic              main_done;
	logic              erase_done;
	logic [7:0]        dly;
	logic [7:0]        su_dly;
	logic              hang;
	logic [31:0]       rdq;
	pms_pkg::pms_cmd_s cmd;
	pms_pkg::pms_lvl_s lvl;
	logic [6:0]        seq[$];
	int                since;
	int                steps;
	int                error_cnt;
	int                comparisons;
	pms_mode_seq #(.WDOG_CYC(200), .MS_CYC(10), .BLINK_CYC(50), .HALF_CYC(4)) u_dut (
		.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .run_sw(run_sw), .mres_sw(mres_sw), .img_done(img_done),
		.startup_done(startup_done), .main_done(main_done), .bp_hit(bp_hit), .erase_done(erase_done),
		.cmd(cmd), .lvl(lvl));
	pms_core_model u_core (
		.core_clk(core_clk), .rst(rst), .cmd(cmd), .lvl(lvl), .dly(dly), .su_dly(su_dly), .hang(hang),
		.img_done(img_done), .startup_done(startup_done), .main_done(main_done), .erase_done(erase_done));
	// ==========================================
	// Clock and pulse monitors
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Order of issued commands and step count
	always @(negedge core_clk) begin
		if (rst === 1'b0 && cmd !== 7'h00)
			seq.push_back(cmd);
		if (cmd.step_go === 1'b1)
			steps++;
	end
	// Cycles since the last input-image clear
	always @(posedge core_clk) since <= (cmd.clr_in === 1'b1) ? 0 : since + 1;
	// ==========================================
	// Closing and bus tasks
	task conclude;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task fail_to(input string nm);
		error_cnt++;
		$display("MISMATCH %s exp done got timeout", nm);
		conclude();
	endtask : fail_to
	task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rdq = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 20)
			fail_to("bus");
	endtask : acc
	task wr(input logic [3:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task rd(input logic [3:0] a);
		acc(1'b0, a, 32'h0000_0000);
	endtask : rd
	task wait_mode(input logic [1:0] m, input int lim);
		int n;
		n = 0;
		rd(4'hc);
		while (rdq[1:0] !== m && n < lim) begin
			rd(4'hc);
			n++;
		end
		if (rdq[1:0] !== m)
			fail_to("mode");
		@(negedge core_clk);
	endtask : wait_mode
	// ==========================================
	// Scenarios
	task t_reset;
		`CHK("inhibit", 1'b1, lvl.output_inhibit)
		`CHK("stop_indicator", 1'b1, lvl.stop_indicator)
		`CHK("run_indicator", 1'b0, lvl.run_indicator)
		rd(4'hc);
		`CHK("stat", 32'h0000_0000, rdq)
		rd(4'h8);
		`CHK("cyclim", 32'h0000_0064, rdq)
		wr(4'h2, 32'hffff_ffff);
		rd(4'h2);
		`CHK("unmapped", 32'h0000_0000, rdq)
	endtask : t_reset
	task t_start;
		int lows;
		int bad;
		int n;
		logic [6:0] ord[7];
		ord = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h08};
		lows = 0;
		bad = 0;
		seq.delete();
		wr(4'h0, 32'h0000_0001);
		for (n = 0; n < 140 && !(since >= 90 && since < 500); n++) begin
			@(negedge core_clk);
			if (since >= 24 && since <= 44 && lvl.run_indicator === 1'b0)
				lows++;
			if (since >= 70 && since < 500 && lvl.run_indicator !== 1'b1)
				bad++;
			if (since == 3) begin
				`CHK("su inhibit", 1'b1, lvl.output_inhibit)
				`CHK("su stop_indicator", 1'b0, lvl.stop_indicator)
			end
		end
		`CHK("blink", 1'b1, lows > 0)
		`CHK("steady", 0, bad)
		`CHK("run inhibit", 1'b0, lvl.output_inhibit)
		`CHK("run stop_indicator", 1'b0, lvl.stop_indicator)
		`CHK("timers", 1'b1, lvl.timers_run)
		for (n = 0; n < 7; n++)
			`CHK("order", ord[n], seq[n])
	endtask : t_start
	task t_hold;
		int n;
		int hi;
		int st;
		@(posedge core_clk);
		dly <= 8'h08;
		wr(4'h4, 32'h0000_0005);
		n = 0;
		while (cmd.main_go !== 1'b1 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 100)
			fail_to("main_go");
		@(posedge core_clk);
		bp_hit <= 1'b1;
		@(posedge core_clk);
		bp_hit <= 1'b0;
		wait_mode(2'h3, 10);
		`CHK("hold", 2'h3, rdq[1:0])
		`CHK("hold inhibit", 1'b1, lvl.output_inhibit)
		`CHK("hold stop_indicator", 1'b1, lvl.stop_indicator)
		`CHK("hold exec", 1'b0, lvl.exec_enable)
		`CHK("hold timers", 1'b0, lvl.timers_run)
		n = 0;
		hi = 0;
		repeat (12) begin
			@(negedge core_clk);
			if (lvl.run_indicator === 1'b1)
				hi++;
		end
		`CHK("hold blink", 1'b1, hi > 0 && hi < 12)
		st = steps;
		wr(4'h0, 32'h0000_0008);
		repeat (6) @(negedge core_clk);
		`CHK("step", st + 1, steps)
		wr(4'h4, 32'h0000_0007);
		wr(4'h0, 32'h0000_0008);
		repeat (6) @(negedge core_clk);
		`CHK("step refused", st + 1, steps)
		rd(4'hc);
		`CHK("refused flag", 1'b1, rdq[9])
		wr(4'h4, 32'hffff_ffff);
		rd(4'h4);
		`CHK("brkp", 32'h0000_000f, rdq)
		wr(4'h0, 32'h0000_0010);
		wait_mode(2'h2, 10);
		`CHK("resume flag", 1'b0, rdq[9])
		wr(4'h4, 32'h0000_0008);
	endtask : t_hold
	task t_stop;
		int n;
		wr(4'h0, 32'h0000_0002);
		wait_mode(2'h0, 10);
		`CHK("stop inhibit", 1'b1, lvl.output_inhibit)
		`CHK("analog safe", 1'b1, lvl.analog_safe)
		`CHK("analog subst", 1'b1, lvl.analog_subst)
		`CHK("stop_indicator", 1'b1, lvl.stop_indicator)
		`CHK("run_indicator", 1'b0, lvl.run_indicator)
		n = seq.size();
		repeat (20) @(negedge core_clk);
		`CHK("no clears", n, seq.size())
		@(posedge core_clk);
		run_sw <= 1'b1;
		wait_mode(2'h2, 60);
		@(posedge core_clk);
		bp_hit <= 1'b1;
		@(posedge core_clk);
		bp_hit <= 1'b0;
		repeat (4) @(negedge core_clk);
		rd(4'hc);
		`CHK("bp inactive", 2'h2, rdq[1:0])
		run_sw <= 1'b0;
		wait_mode(2'h0, 10);
	endtask : t_stop
	task t_supervise;
		wr(4'h8, 32'h0000_0000);
		rd(4'h8);
		`CHK("cyclim min", 32'h0000_0001, rdq)
		@(posedge core_clk);
		su_dly <= 8'hfa;
		dly <= 8'h04;
		wr(4'h0, 32'h0000_0001);
		wait_mode(2'h2, 150);
		`CHK("unsupervised", 2'h2, rdq[1:0])
		wait_mode(2'h0, 40);
		`CHK("cycle fault", 1'b1, rdq[8])
		wr(4'h8, 32'h0000_0064);
		hang <= 1'b1;
		su_dly <= 8'h03;
		wr(4'h0, 32'h0000_0001);
		wait_mode(2'h2, 30);
		wait_mode(2'h0, 120);
		`CHK("watchdog", 2'b01, rdq[8:7])
		hang <= 1'b0;
	endtask : t_supervise
	task t_mres;
		int n;
		int bad;
		@(posedge core_clk);
		su_dly <= 8'h28;
		mres_sw <= 1'b1;
		n = 0;
		repeat (16) begin
			@(negedge core_clk);
			if (lvl.stop_indicator === 1'b0)
				n++;
		end
		`CHK("mres blink", 1'b1, n > 0)
		wr(4'h0, 32'h0000_0001);
		rd(4'hc);
		`CHK("erasing", 3'h4, {rdq[6], rdq[1:0]})
		`CHK("erase req", 1'b1, lvl.erase_req)
		for (n = 0; n < 80 && lvl.erase_req !== 1'b0; n++)
			@(negedge core_clk);
		bad = 0;
		repeat (16) begin
			@(negedge core_clk);
			if (lvl.stop_indicator !== 1'b1)
				bad++;
		end
		`CHK("mres done", 0, bad)
		@(posedge core_clk);
		mres_sw <= 1'b0;
		wr(4'h0, 32'h0000_0004);
		repeat (3) @(negedge core_clk);
		`CHK("tool mres", 1'b1, lvl.erase_req)
	endtask : t_mres
	// ==========================================
	// Main sequence
	initial begin
		rst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		run_sw = 1'b0;
		mres_sw = 1'b0;
		bp_hit = 1'b0;
		dly = 8'h02;
		su_dly = 8'h0a;
		hang = 1'b0;
		since = 1000;
		steps = 0;
		error_cnt = 0;
		comparisons = 0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		t_reset();
		t_start();
		t_hold();
		t_stop();
		t_supervise();
		t_mres();
		conclude();
	end
endmodule : testbench
